// ### rtl/spdc_pkg.sv
// constants for the switch port device capabilities register bank
package spdc_pkg;

	// ==========================================================
	// configuration space offsets
	localparam logic [7:0] CAP_OFFSET  = 8'hc4;
	localparam logic [7:0] CTRL_OFFSET = 8'hc8;

	// ==========================================================
	// payload size encodings
	localparam logic [2:0] MPS_128 = 3'h0;
	localparam logic [2:0] MPS_256 = 3'h1;
	localparam logic [2:0] MPS_512 = 3'h2;

	// ==========================================================
	// field positions in the capability word
	localparam int MPS_LSB   = 0;
	localparam int MPS_MSB   = 2;
	localparam int PHF_LSB   = 3;
	localparam int PHF_MSB   = 4;
	localparam int ETAG_BIT  = 5;
	localparam int L0S_LSB   = 6;
	localparam int L0S_MSB   = 8;
	localparam int L1_LSB    = 9;
	localparam int L1_MSB    = 11;
	localparam int RBER_BIT  = 15;
	localparam int SPLV_LSB  = 18;
	localparam int SPLV_MSB  = 25;
	localparam int SPLS_LSB  = 26;
	localparam int SPLS_MSB  = 27;

	// field positions in the device control word
	localparam int CTRL_MPS_LSB = 5;
	localparam int CTRL_MPS_MSB = 7;
	localparam int CTRL_MPS_BE  = 0;

	// ==========================================================
	// reset and constant values
	localparam logic [1:0] PHF_VALUE   = 2'h0;
	localparam logic       ETAG_VALUE  = 1'h0;
	localparam logic [2:0] L0S_VALUE   = 3'h0;
	localparam logic [2:0] L1_VALUE    = 3'h0;
	localparam logic       RBER_RESET  = 1'h1;
	localparam logic [7:0] SPLV_RESET  = 8'h00;
	localparam logic [1:0] SPLS_RESET  = 2'h0;
	localparam logic [2:0] CTRL_MPS_RESET = 3'h0;
	localparam logic [31:0] ZERO_WORD  = 32'h00000000;

	// strap sampling: two synchroniser stages then one load cycle
	localparam logic [1:0] STRAP_WAIT  = 2'h2;

endpackage

// ### rtl/spdc_port_device_capabilities.sv
// capability register and payload-size control of one switch port
// ==========================================================
// Notes on behaviour
// (R1) payload capability in bits 2:0, three codes
// (R2) reset payload code follows large payload strap
// (R3) sideband or eeprom loader may override payload
// (R4) phantom function field always reads 00b
// (R5) extended tag bit always reads zero
// (R6) l0s acceptable latency constant 000b
// (R7) l1 acceptable latency constant 000b
// (R8) role based error bit resets 1, overridable
// (R9) upstream only: power limit value, reset 00h
// (R10) value loaded from received power limit message
// (R11) upstream only: power limit scale, reset 00b
// (R12) control payload write clamped to capability
// (R13) reserved bits zero, capability writes ignored
`timescale 1ns/1ps
`default_nettype none

module spdc_port_device_capabilities
	import spdc_pkg::*;
#(
	parameter bit UPSTREAM = 1'b1
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// strap pin
	input  wire logic        large_payload_strap,
	// configuration access
	input  wire logic        cfg_rd,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_rd_valid,
	// sideband serial and eeprom loader
	input  wire logic        sb_mps_wr,
	input  wire logic [2:0]  sb_mps,
	input  wire logic        sb_rber_wr,
	input  wire logic        sb_rber,
	// received slot power limit message
	input  wire logic        spl_msg_valid,
	input  wire logic [7:0]  spl_msg_value,
	input  wire logic [1:0]  spl_msg_scale,
	// programmed payload size for the datapath
	output logic      [2:0]  mps_setting
);

	// ==========================================================
	// helpers
	function automatic logic mps_code_legal(input logic [2:0] code);
		return (code == MPS_128) || (code == MPS_256) || (code == MPS_512);
	endfunction

	// codes grow with the payload size, so a plain compare finds the larger one
	function automatic logic [2:0] mps_clamp(input logic [2:0] req, input logic [2:0] cap);
		return (req > cap) ? cap : req;
	endfunction

	// ==========================================================
	// strap synchroniser and capture after reset release
	logic       strap_meta;
	logic       strap_sync;
	logic [1:0] strap_cnt;
	logic       strap_done;
	logic       strap_load;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_meta <= 1'b0;
			strap_sync <= 1'b0;
		end else begin
			strap_meta <= large_payload_strap;
			strap_sync <= strap_meta;
		end
	end

	// the strap is only sampled once the synchroniser holds real pin data;
	// it must stay steady from reset release until that load
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_cnt <= 2'h0;
		end else if (strap_cnt != STRAP_WAIT) begin
			strap_cnt <= strap_cnt + 2'h1;
		end
	end

	// a single load strobe, so a later loader write is never undone by the strap
	assign strap_load = !strap_done && (strap_cnt == STRAP_WAIT);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_done <= 1'b0;
		end else if (strap_load) begin
			strap_done <= 1'b1;
		end
	end

	// ==========================================================
	// payload capability
	logic [2:0] mps_cap;
	logic       sb_mps_take;

	// reserved loader codes are dropped so the field never shows one
	assign sb_mps_take = sb_mps_wr && mps_code_legal(sb_mps);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mps_cap <= MPS_256; // R2
		end else if (sb_mps_take) begin
			// loader wins over the strap
			mps_cap <= sb_mps; // R3
		end else if (strap_load) begin
			mps_cap <= strap_sync ? MPS_512 : MPS_256; // R2
		end
	end

	// ==========================================================
	// role based error reporting
	// loader value is taken as is; both settings are legal
	logic rber;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rber <= RBER_RESET; // R8
		end else if (sb_rber_wr) begin
			rber <= sb_rber; // R8
		end
	end

	// ==========================================================
	// captured slot power limit, upstream port only
	logic [7:0] spl_value;
	logic [1:0] spl_scale;
	logic       spl_take;

	// a downstream port ignores the message and keeps its reset fields
	assign spl_take = UPSTREAM && spl_msg_valid; // R9 R11

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spl_value <= SPLV_RESET; // R9
			spl_scale <= SPLS_RESET; // R11
		end else if (spl_take) begin
			spl_value <= spl_msg_value; // R10
			spl_scale <= spl_msg_scale; // R11
		end
	end

	// ==========================================================
	// programmed payload size in device control
	logic        ctrl_hit_wr;
	logic [31:0] ctrl_word;
	assign ctrl_hit_wr = cfg_wr && (cfg_addr == CTRL_OFFSET) && cfg_be[CTRL_MPS_BE];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mps_setting <= CTRL_MPS_RESET;
		end else if (ctrl_hit_wr) begin
			mps_setting <= mps_clamp(cfg_wdata[CTRL_MPS_MSB:CTRL_MPS_LSB], mps_cap); // R12
		end else if (mps_setting > mps_cap) begin
			// a later capability drop must not leave an oversize setting behind
			mps_setting <= mps_cap; // R12
		end
	end

	// ==========================================================
	// read path; capability writes fall through untouched
	logic [31:0] cap_word;

	// every bit not named below reads as zero
	always_comb begin
		cap_word = ZERO_WORD; // R13
		cap_word[MPS_MSB:MPS_LSB] = mps_cap; // R1
		cap_word[PHF_MSB:PHF_LSB] = PHF_VALUE; // R4
		cap_word[ETAG_BIT] = ETAG_VALUE; // R5
		cap_word[L0S_MSB:L0S_LSB] = L0S_VALUE; // R6
		cap_word[L1_MSB:L1_LSB] = L1_VALUE; // R7
		cap_word[RBER_BIT] = rber; // R8
		cap_word[SPLV_MSB:SPLV_LSB] = UPSTREAM ? spl_value : SPLV_RESET; // R9
		cap_word[SPLS_MSB:SPLS_LSB] = UPSTREAM ? spl_scale : SPLS_RESET; // R11
	end

	always_comb begin
		ctrl_word = ZERO_WORD;
		ctrl_word[CTRL_MPS_MSB:CTRL_MPS_LSB] = mps_setting; // R12
	end

	// ==========================================================
	// read strobe, one cycle after each read request
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_rd_valid <= 1'b0;
		end else begin
			cfg_rd_valid <= cfg_rd;
		end
	end

	// ==========================================================
	// read data, held until the next read so a slow master may take it late
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_rdata <= ZERO_WORD;
		end else if (cfg_rd) begin
			unique case (cfg_addr)
				CAP_OFFSET: begin
					cfg_rdata <= cap_word;
				end
				CTRL_OFFSET: begin
					cfg_rdata <= ctrl_word;
				end
				default: begin
					cfg_rdata <= ZERO_WORD; // R13
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ### verification/spdc_asserts.sv
// concurrent checks on the capability register ports
`timescale 1ns/1ps
`default_nettype none
module spdc_asserts
	import spdc_pkg::*;
#(
	parameter bit UPSTREAM = 1'b1
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        cfg_rd,
	input wire logic        cfg_wr,
	input wire logic [7:0]  cfg_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_rd_valid,
	input wire logic        sb_rber_wr,
	input wire logic        sb_rber,
	input wire logic        spl_msg_valid,
	input wire logic [7:0]  spl_msg_value,
	input wire logic [1:0]  spl_msg_scale,
	input wire logic [2:0]  mps_setting
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire cap_rd = cfg_rd && cfg_addr == CAP_OFFSET;
	wire ctl_rd = cfg_rd && cfg_addr == CTRL_OFFSET;
	// ==========================================================
	// assertions
	a_mps_code: assert property (cap_rd |=> cfg_rd_valid && cfg_rdata[2:0] <= MPS_512)
		else $error("bad payload code");
	a_fixed_zero: assert property (cap_rd |=> cfg_rdata[14:3] == 12'h000
		&& cfg_rdata[17:16] == 2'h0 && cfg_rdata[31:28] == 4'h0) else $error("fixed field set");
	a_unmapped_zero: assert property (cfg_rd && !cap_rd && !ctl_rd |=> cfg_rdata == ZERO_WORD)
		else $error("unmapped read not zero");
	a_rber_load: assert property (sb_rber_wr ##1 !sb_rber_wr ##1 cap_rd
		|=> cfg_rdata[RBER_BIT] == $past(sb_rber, 3)) else $error("rber not loaded");
	a_spl_capture: assert property (spl_msg_valid ##1 !spl_msg_valid ##1 cap_rd
		|=> cfg_rdata[27:18] == (UPSTREAM ? {$past(spl_msg_scale, 3), $past(spl_msg_value, 3)}
			: 10'h000))
		else $error("power limit not captured");
	a_small_mps: assert property (cfg_wr && cfg_addr == CTRL_OFFSET && cfg_be[0]
		&& cfg_wdata[7:5] == MPS_128 |=> mps_setting == MPS_128) else $error("mps not stored");
	a_ctrl_read: assert property (ctl_rd |=> cfg_rdata == {24'h0, $past(mps_setting), 5'h0})
		else $error("control read mismatch");
	a_reset_quiet: assert property ($fell(rst) |-> mps_setting == MPS_128 && !cfg_rd_valid)
		else $error("reset values wrong");
	c_spl: cover property (spl_msg_valid);
	c_ctl_wr: cover property (cfg_wr && cfg_addr == CTRL_OFFSET);
	c_rber: cover property (sb_rber_wr);
endmodule
`default_nettype wire

// ### verification/spdc_spl_model.sv
// upstream link partner sending slot power limit messages
`timescale 1ns/1ps
`default_nettype none
module spdc_spl_model (
	input  wire logic       clk,
	output logic            valid,
	output logic      [7:0] value,
	output logic      [1:0] scale
);
	initial begin
		valid = 1'b0;
		value = 8'h5a;
		scale = 2'h2;
	end
	// fields hold junk outside the pulse so a stale capture shows
	task automatic send(input logic [7:0] v, input logic [1:0] s, input int gap);
		repeat (gap + 1) @(posedge clk);
		#1;
		valid = 1'b1;
		value = v;
		scale = s;
		@(posedge clk);
		#1;
		valid = 1'b0;
		value = ~v;
		scale = ~s;
	endtask
endmodule
`default_nettype wire

// ### verification/switch_port_device_capabilities_tb.sv
// self-checking bench for the port capability register
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module switch_port_device_capabilities_tb import spdc_pkg::*;;
	logic        clk = 1'b0, rst = 1'b1, large_payload_strap = 1'b0;
	logic        cfg_rd = 1'b0, cfg_wr = 1'b0, sb_mps_wr = 1'b0, sb_rber_wr = 1'b0;
	logic        sb_rber = 1'b1, e_rber, cfg_rd_valid, cfg_rd_valid_dn;
	logic [7:0]  cfg_addr = 8'h00, e_v;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata, cfg_rdata_dn;
	logic [2:0]  sb_mps = 3'h0, e_mps, mps_setting, mps_setting_dn;
	logic [1:0]  e_s;
	wire logic   spl_msg_valid;
	wire logic [7:0] spl_msg_value;
	wire logic [1:0] spl_msg_scale;
	int          err_count = 0, total_checks = 0;
	spdc_port_device_capabilities #(.UPSTREAM(1'b1)) u_dut (.clk, .rst, .large_payload_strap,
		.cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .sb_mps_wr,
		.sb_mps, .sb_rber_wr, .sb_rber, .spl_msg_valid, .spl_msg_value, .spl_msg_scale, .mps_setting);
	spdc_port_device_capabilities #(.UPSTREAM(1'b0)) u_dut_dn (.clk, .rst,
		.large_payload_strap, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata,
		.cfg_rdata(cfg_rdata_dn), .cfg_rd_valid(cfg_rd_valid_dn), .sb_mps_wr, .sb_mps,
		.sb_rber_wr, .sb_rber, .spl_msg_valid, .spl_msg_value, .spl_msg_scale,
		.mps_setting(mps_setting_dn));
	spdc_spl_model u_spl (.clk, .valid(spl_msg_valid), .value(spl_msg_value), .scale(spl_msg_scale));
	always #20 clk = ~clk;
	function automatic logic [31:0] cap_exp();
		return {4'h0, e_s, e_v, 2'h0, e_rber, 12'h000, e_mps};
	endfunction
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		tick();
		cfg_addr = a;
		cfg_rd = 1'b1;
		tick();
		cfg_rd = 1'b0;
		`CHK(cfg_rd_valid, 1'b1)
		`CHK(cfg_rdata, exp)
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		tick();
		cfg_addr = a;
		cfg_be = be;
		cfg_wdata = d;
		cfg_wr = 1'b1;
		tick();
		cfg_wr = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		tick();
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask
	// ==========================================================
	// scenarios
	task automatic s_reset(input logic s);
		rst = 1'b1;
		large_payload_strap = s;
		repeat (4) tick();
		rst = 1'b0;
		rd(CAP_OFFSET, {16'h0000, RBER_RESET, 12'h000, MPS_256});
		e_mps = s ? MPS_512 : MPS_256;
		e_rber = 1'b1;
		e_v = 8'h00;
		e_s = 2'h0;
		rd(CAP_OFFSET, cap_exp());
		`CHK(cfg_rdata_dn, cap_exp())
		rd(CTRL_OFFSET, ZERO_WORD);
	endtask
	task automatic s_loader();
		for (int c = 0; c < 8; c++) begin
			sb_mps = 3'(c);
			pulse(sb_mps_wr);
			if (3'(c) <= MPS_512) e_mps = 3'(c);
			rd(CAP_OFFSET, cap_exp());
		end
		sb_rber = 1'b0;
		pulse(sb_rber_wr);
		e_rber = 1'b0;
		rd(CAP_OFFSET, cap_exp());
	endtask
	task automatic s_clamp();
		logic [2:0] e_set;
		sb_mps = MPS_256;
		pulse(sb_mps_wr);
		e_mps = MPS_256;
		for (int w = 0; w < 8; w++) begin
			e_set = (3'(w) > e_mps) ? e_mps : 3'(w);
			wr(CTRL_OFFSET, 4'h1, {24'h0, 3'(w), 5'h0});
			rd(CTRL_OFFSET, {24'h0, e_set, 5'h0});
			`CHK(mps_setting, e_set)
			`CHK(mps_setting_dn, e_set)
		end
		sb_mps = MPS_128;
		pulse(sb_mps_wr);
		e_mps = MPS_128;
		rd(CTRL_OFFSET, ZERO_WORD);
		`CHK(mps_setting, MPS_128)
		wr(CAP_OFFSET, 4'hf, 32'hffffffff);
		rd(CAP_OFFSET, cap_exp());
		rd(8'h10, ZERO_WORD);
	endtask
	task automatic s_power();
		u_spl.send(8'ha5, 2'h3, 0);
		e_v = 8'ha5;
		e_s = 2'h3;
		rd(CAP_OFFSET, cap_exp());
		`CHK(cfg_rd_valid_dn, 1'b1)
		`CHK(cfg_rdata_dn, ({16'h0000, e_rber, 12'h000, e_mps}))
		u_spl.send(8'h3c, 2'h1, 5);
		e_v = 8'h3c;
		e_s = 2'h1;
		rd(CAP_OFFSET, cap_exp());
		`CHK(cfg_rdata_dn, ({16'h0000, e_rber, 12'h000, e_mps}))
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		s_reset(1'b1);
		s_reset(1'b0);
		s_loader();
		s_clamp();
		s_power();
		finish_test();
	end
	initial begin
		#50000;
		err_count++;
		finish_test();
	end
endmodule
bind spdc_port_device_capabilities spdc_asserts #(.UPSTREAM(UPSTREAM)) u_chk (.clk, .rst,
	.cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rd_valid, .sb_rber_wr,
	.sb_rber, .spl_msg_valid, .spl_msg_value, .spl_msg_scale, .mps_setting);
`default_nettype wire
